// >>> design/drc_consts.vh
`ifndef DRC_CONSTS_VH
`define DRC_CONSTS_VH
// =====================================================
// register byte offsets
`define DRC_OFS_CTRL_FIRST 8'h00
`define DRC_OFS_CTRL_SECOND 8'h04
`define DRC_OFS_STATUS 8'h08
// =====================================================
// first control register fields
`define DRC_BIT_ENABLE 7
`define DRC_BIT_OUT_CONNECT 5
`define DRC_BIT_LOW_POWER 0
`define DRC_POS_PSEL_LSB 2
`define DRC_POS_NSEL 1
// second control register fields
`define DRC_TAP_MSB 4
`define DRC_TAP_LSB 0
// =====================================================
// reset values
`define DRC_RST_FIRST 8'h00
`define DRC_RST_TAP 5'h00
`define DRC_RST_PSEL 2'h0
// =====================================================
// bus answers
`define DRC_RESP_OKAY 2'h0
`define DRC_RESP_SLVERR 2'h2
`endif

// >>> design/drc_control.v
`timescale 1ns/1ps
`default_nettype none
`include "drc_consts.vh"
module drc_control (
  input wire CLK,
  input wire RST,
  input wire SLEEP,
  input wire WAKE,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  output reg CONVERTER_ENABLE,
  output reg REF_OUTPUT_PIN_CONNECT,
  output reg POSITIVE_SOURCE_CONNECT,
  output reg NEGATIVE_SOURCE_CONNECT,
  output reg [1:0] POSITIVE_SOURCE_SELECT,
  output reg NEGATIVE_SOURCE_SELECT,
  output reg [4:0] LADDER_TAP_SELECT,
  output reg ASLEEP
);
// =====================================================
// control registers
reg converter_enable;
reg out_connect;
reg low_power_source_select;
reg [1:0] positive_source_select;
reg negative_source_select;
reg [4:0] ladder_tap_select;
reg sleep_s1;
reg sleep_s2;
reg wake_s1;
reg wake_s2;
reg asleep;
// =====================================================
// write channel: address and data taken together, either order by holding
reg aw_held;
reg w_held;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
wire aw_now = aw_held || (S_AXI_AWVALID && S_AXI_AWREADY);
wire w_now = w_held || (S_AXI_WVALID && S_AXI_WREADY);
wire [7:0] wa = aw_held ? aw_addr : S_AXI_AWADDR;
wire [31:0] wd = w_held ? w_data : S_AXI_WDATA;
// a write with lane 0 strobe low is answered but leaves the registers alone
wire wlane = w_held ? w_strb[0] : S_AXI_WSTRB[0];
wire do_write = aw_now && w_now && !S_AXI_BVALID;
// =====================================================
// address decoding
function mapped;
  input [7:0] a;
  begin
    mapped = (a == `DRC_OFS_CTRL_FIRST) ||
      (a == `DRC_OFS_CTRL_SECOND) ||
      (a == `DRC_OFS_STATUS);
  end
endfunction

// one decode for both answers keeps write and read errors alike
function [1:0] resp_for;
  input [7:0] a;
  begin
    resp_for = mapped(a) ? `DRC_RESP_OKAY : `DRC_RESP_SLVERR;
  end
endfunction

always @(posedge CLK or posedge RST) begin
  if (RST) begin
    aw_held <= 1'b0;
    w_held <= 1'b0;
    aw_addr <= 8'h00;
    w_data <= 32'h00000000;
    w_strb <= 4'h0;
    S_AXI_BVALID <= 1'b0;
    S_AXI_BRESP <= `DRC_RESP_OKAY;
  end else begin
    if (do_write) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= resp_for(wa);
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end
end
// =====================================================
// register writes; sleep and wake never touch these
always @(posedge CLK or posedge RST) begin
  if (RST) begin
    converter_enable <= 1'b0;
    out_connect <= 1'b0;
    low_power_source_select <= 1'b0;
    positive_source_select <= `DRC_RST_PSEL;
    negative_source_select <= 1'b0;
    ladder_tap_select <= `DRC_RST_TAP;
  end else if (do_write && wlane) begin
    if (wa == `DRC_OFS_CTRL_FIRST) begin
      converter_enable <= wd[`DRC_BIT_ENABLE];
      out_connect <= wd[`DRC_BIT_OUT_CONNECT];
      positive_source_select <= wd[`DRC_POS_PSEL_LSB+1:`DRC_POS_PSEL_LSB];
      negative_source_select <= wd[`DRC_POS_NSEL];
      low_power_source_select <= wd[`DRC_BIT_LOW_POWER];
    end else if (wa == `DRC_OFS_CTRL_SECOND) begin
      // the whole tap field moves in one write, so no mixed tap is ever applied
      ladder_tap_select <= wd[`DRC_TAP_MSB:`DRC_TAP_LSB];
    end
  end
end
// =====================================================
// sleep state, pins synchronised; status only, controls unaffected
always @(posedge CLK or posedge RST) begin
  if (RST) begin
    sleep_s1 <= 1'b0;
    sleep_s2 <= 1'b0;
    wake_s1 <= 1'b0;
    wake_s2 <= 1'b0;
    asleep <= 1'b0;
  end else begin
    sleep_s1 <= SLEEP;
    sleep_s2 <= sleep_s1;
    wake_s1 <= WAKE;
    wake_s2 <= wake_s1;
    // wake wins over a sleep seen in the same cycle
    if (wake_s2)
      asleep <= 1'b0;
    else if (sleep_s2)
      asleep <= 1'b1;
  end
end
// =====================================================
// ladder source switches; disabled clamp draws no ladder current
// enabled ladder uses both ends; disabled keeps only the clamp end
wire next_positive_connect = converter_enable || low_power_source_select;
wire next_negative_connect = converter_enable || !low_power_source_select;
always @(posedge CLK or posedge RST) begin
  if (RST) begin
    CONVERTER_ENABLE <= 1'b0;
    REF_OUTPUT_PIN_CONNECT <= 1'b0;
    POSITIVE_SOURCE_CONNECT <= 1'b0;
    NEGATIVE_SOURCE_CONNECT <= 1'b0;
    POSITIVE_SOURCE_SELECT <= `DRC_RST_PSEL;
    NEGATIVE_SOURCE_SELECT <= 1'b0;
    LADDER_TAP_SELECT <= `DRC_RST_TAP;
    ASLEEP <= 1'b0;
  end else begin
    CONVERTER_ENABLE <= converter_enable;
    REF_OUTPUT_PIN_CONNECT <= out_connect;
    POSITIVE_SOURCE_CONNECT <= next_positive_connect;
    NEGATIVE_SOURCE_CONNECT <= next_negative_connect;
    POSITIVE_SOURCE_SELECT <= positive_source_select;
    NEGATIVE_SOURCE_SELECT <= negative_source_select;
    LADDER_TAP_SELECT <= ladder_tap_select;
    ASLEEP <= asleep;
  end
end
// =====================================================
// read channel, one cycle answer
// status shows the switches as driven, one cycle behind the controls
function [31:0] read_word;
  input [7:0] a;
  begin
    case (a)
      `DRC_OFS_CTRL_FIRST: read_word = {24'h000000, converter_enable, 1'b0, out_connect, 1'b0,
        positive_source_select, negative_source_select, low_power_source_select};
      `DRC_OFS_CTRL_SECOND: read_word = {27'h0000000, ladder_tap_select};
      `DRC_OFS_STATUS: read_word = {29'h00000000, asleep, NEGATIVE_SOURCE_CONNECT, POSITIVE_SOURCE_CONNECT};
      default: read_word = 32'h00000000;
    endcase
  end
endfunction

assign S_AXI_ARREADY = !S_AXI_RVALID;
always @(posedge CLK or posedge RST) begin
  if (RST) begin
    S_AXI_RVALID <= 1'b0;
    S_AXI_RDATA <= 32'h00000000;
    S_AXI_RRESP <= `DRC_RESP_OKAY;
  end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
    S_AXI_RVALID <= 1'b1;
    S_AXI_RRESP <= resp_for(S_AXI_ARADDR);
    S_AXI_RDATA <= read_word(S_AXI_ARADDR);
  end else if (S_AXI_RVALID && S_AXI_RREADY) begin
    S_AXI_RVALID <= 1'b0;
  end
end
endmodule // drc_control
`default_nettype wire

// >>> verification/drc_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module drc_control_monitor (
  input wire CLK,
  input wire RST,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire CONVERTER_ENABLE,
  input wire REF_OUTPUT_PIN_CONNECT,
  input wire POSITIVE_SOURCE_CONNECT,
  input wire NEGATIVE_SOURCE_CONNECT,
  input wire [1:0] POSITIVE_SOURCE_SELECT,
  input wire NEGATIVE_SOURCE_SELECT,
  input wire [4:0] LADDER_TAP_SELECT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire [9:0] ctl = {CONVERTER_ENABLE, REF_OUTPUT_PIN_CONNECT, POSITIVE_SOURCE_SELECT,
    NEGATIVE_SOURCE_SELECT, LADDER_TAP_SELECT};
  // ==========
  // reset and source switches
  a_reset_off: assert property ($past(RST) |-> !CONVERTER_ENABLE && !REF_OUTPUT_PIN_CONNECT)
    else $error("converter live after reset");
  a_reset_tap: assert property ($past(RST) |-> LADDER_TAP_SELECT == 5'h00)
    else $error("tap not cleared by reset");
  a_clamp_one: assert property (!RST && !CONVERTER_ENABLE && !$past(RST) |->
    POSITIVE_SOURCE_CONNECT != NEGATIVE_SOURCE_CONNECT)
    else $error("disabled ladder not cut at one end");
  a_enable_both: assert property (CONVERTER_ENABLE |-> POSITIVE_SOURCE_CONNECT && NEGATIVE_SOURCE_CONNECT)
    else $error("enabled ladder not fully connected");
  // only a bus write may move the controls; sleep and wake must not
  a_wake_keep: assert property (!RST && !$past(RST) && !$past(S_AXI_BVALID) &&
    !$past(S_AXI_BVALID, 2) |-> $stable(ctl))
    else $error("controls moved without a write");
  a_bresp_once: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answered twice");
  a_rresp_once: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answered twice");
  c_enabled: cover property (CONVERTER_ENABLE);
  c_clamp_high: cover property (!CONVERTER_ENABLE && POSITIVE_SOURCE_CONNECT);
  c_tap_full: cover property (LADDER_TAP_SELECT == 5'h1f);
endmodule // drc_control_monitor
bind drc_control drc_control_monitor i_drc_control_monitor (.CLK(CLK), .RST(RST),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .CONVERTER_ENABLE(CONVERTER_ENABLE), .REF_OUTPUT_PIN_CONNECT(REF_OUTPUT_PIN_CONNECT),
  .POSITIVE_SOURCE_CONNECT(POSITIVE_SOURCE_CONNECT), .NEGATIVE_SOURCE_CONNECT(NEGATIVE_SOURCE_CONNECT),
  .POSITIVE_SOURCE_SELECT(POSITIVE_SOURCE_SELECT), .NEGATIVE_SOURCE_SELECT(NEGATIVE_SOURCE_SELECT),
  .LADDER_TAP_SELECT(LADDER_TAP_SELECT));
`default_nettype wire

// >>> verification/drc_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module drc_control_tb;
  logic CLK = 0, RST = 1, SLEEP = 0, WAKE = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [3:0] ws = 4'hf;
  logic [31:0] wd = 32'h0, d;
  wire awr, wrd, bv, arr, rv, ce, rp, pc, nc, ns, asl;
  wire [1:0] bres, rres, ps;
  wire [31:0] rdat;
  wire [4:0] tap;
  wire [10:0] pins = {ce, rp, ps, ns, tap, asl};
  logic [33:0] q[$];
  int fail_count = 0, compares = 0, cyc = 0;
  always #5 CLK = ~CLK;
  drc_control i_drc_control (.CLK(CLK), .RST(RST), .SLEEP(SLEEP), .WAKE(WAKE), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(bres), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rres), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr), .CONVERTER_ENABLE(ce), .REF_OUTPUT_PIN_CONNECT(rp), .POSITIVE_SOURCE_CONNECT(pc),
    .NEGATIVE_SOURCE_CONNECT(nc), .POSITIVE_SOURCE_SELECT(ps), .NEGATIVE_SOURCE_SELECT(ns),
    .LADDER_TAP_SELECT(tap), .ASLEEP(asl));
  // ==========
  // bus tasks and checking
  task give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string n, input [33:0] e, input [33:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v, input [1:0] r);
    q.push_back({r, 32'h0});
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge CLK);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    @(posedge CLK);
  endtask
  task rd(input [7:0] a, input [33:0] e);
    q.push_back(e);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge CLK);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    @(posedge CLK);
  endtask
  // results are paired with the oldest note, so only one transfer may be open
  always @(posedge CLK) if (!RST) begin
    if (bv && br) chk("bresp", q.pop_front(), {bres, 32'h0});
    if (rv && rr) chk("read", q.pop_front(), {rres, rdat});
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict;
    end
  end
  // ==========
  // scenarios
  initial begin
    d = $urandom(32'heb9caced);
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    rd(8'h00, 34'h0);
    rd(8'h04, 34'h0);
    rd(8'h08, 34'h2);
    d = 32'h1 | (($urandom % 4) << 2);
    wr(8'h00, d, 2'h0);
    wr(8'h04, 32'h1f, 2'h0);
    rd(8'h08, 34'h1);
    rd(8'h00, {2'h0, d});
    chk("pins", {2'b00, d[3:2], 1'b0, 5'h1f, 1'b0}, pins);
    wr(8'h00, d | 32'ha0, 2'h0);
    rd(8'h08, 34'h3);
    chk("pins", {2'b11, d[3:2], 1'b0, 5'h1f, 1'b0}, pins);
    wr(8'h00, 32'h2, 2'h0);
    wr(8'h04, 32'h0, 2'h0);
    ws <= 4'he;
    wr(8'h04, 32'h1f, 2'h0);
    ws <= 4'hf;
    rd(8'h04, 34'h0);
    rd(8'h08, 34'h2);
    chk("pins", {4'h0, 1'b1, 5'h00, 1'b0}, pins);
    SLEEP <= 1'b1;
    repeat (5) @(posedge CLK);
    rd(8'h08, 34'h6);
    chk("pins", {4'h0, 1'b1, 5'h00, 1'b1}, pins);
    WAKE <= 1'b1;
    SLEEP <= 1'b0;
    repeat (5) @(posedge CLK);
    WAKE <= 1'b0;
    repeat (4) @(posedge CLK);
    rd(8'h00, 34'h2);
    rd(8'h08, 34'h2);
    chk("pins", {4'h0, 1'b1, 5'h00, 1'b0}, pins);
    rd(8'h0c, 34'h200000000);
    wr(8'h0c, 32'h5, 2'h2);
    wr(8'h04, 32'h1f, 2'h0);
    RST <= 1'b1;
    @(posedge CLK);
    RST <= 1'b0;
    rd(8'h04, 34'h0);
    chk("pins", 11'h000, pins);
    give_verdict;
  end
endmodule // drc_control_tb
`default_nettype wire
